// *** rtl/wrop_map.svh ***
// register offsets, reset values and timing constants of the waveform memory port block
`ifndef WROP_MAP_SVH
`define WROP_MAP_SVH

`define WROP_OFF_OL_PERIOD_HI   8'h2e
`define WROP_OFF_OL_PERIOD_LO   8'h2f
`define WROP_OFF_IMP_COEFF      8'h30
`define WROP_OFF_MEM_PTR_HI     8'hfd
`define WROP_OFF_MEM_PTR_LO     8'hfe
`define WROP_OFF_MEM_DATA       8'hff

`define WROP_RST_OL_PERIOD      10'h0c6
`define WROP_RST_MEM_PTR        16'h0000
`define WROP_RST_IMP_COEFF      8'h00

`define WROP_OL_PERIOD_HI_MSB   1
`define WROP_RAM_AW             10
`define WROP_RAM_WORDS          1024

`define WROP_CLK_PERIOD_NS      50.0
`define WROP_OL_UNIT_US         24.615
`define WROP_OL_UNIT_CYC        ($rtoi((`WROP_OL_UNIT_US * 1000.0) / `WROP_CLK_PERIOD_NS))

`define WROP_OL_PHASE_STEPS     20'h00040
`define WROP_SQUARE_POS         8'h7f
`define WROP_SQUARE_NEG         8'h81

`endif

// *** rtl/wrop_pkg.sv ***
// types shared by the waveform memory port block
package wrop_pkg;

	typedef enum logic [8:0] {
		WROP_ST_IDLE      = 9'h001,
		WROP_ST_ADDR      = 9'h002,
		WROP_ST_ADDR_ACK  = 9'h004,
		WROP_ST_REG       = 9'h008,
		WROP_ST_REG_ACK   = 9'h010,
		WROP_ST_WDATA     = 9'h020,
		WROP_ST_WDATA_ACK = 9'h040,
		WROP_ST_RDATA     = 9'h080,
		WROP_ST_RDATA_ACK = 9'h100
	} wrop_state_t;

	typedef struct packed {
		logic       shape_sine;
		logic [9:0] period;
	} wrop_olcfg_t;

endpackage

// *** rtl/wrop_top.sv ***
// i2c register slave with open-loop period, impedance coefficient and waveform memory port
`timescale 1ns/100ps
`include "wrop_map.svh"

// Operation
// - The open-loop drive period is the 10-bit setting from open_loop_period_high/open_loop_period_low times 24.615 us.
// - The impedance coefficient reads back as an 8-bit value and ignores writes.
// - A 16-bit memory pointer at memory_pointer_high/memory_pointer_low resets to zero and sets where memory access starts.
// - A byte written to memory_data_port is stored in memory at the pointer.
// - Every byte written to memory_data_port, single or burst, advances the pointer by one.
// - Every read of memory_data_port returns the byte at the pointer and then advances the pointer by one.
// - Open-loop drive is a square wave when shape select is 0 and a sine wave when it is 1.
module wrop_top #(
	parameter logic [6:0] DEV_ADDR = 7'h5a // arbitrary bus address
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       ol_enable_i,
	input  wire logic       ol_shape_select_i,
	input  wire logic [7:0] impedance_coeff_i,
	output logic            drive_active_o,
	output logic [7:0]      drive_level_o
);
	localparam logic [9:0] UNIT_CYC = 10'(`WROP_OL_UNIT_CYC);

	// pin synchronisers and filtered levels
	logic [2:0] scl_sync_ff, nxt_scl_sync;
	logic [2:0] sda_sync_ff, nxt_sda_sync;
	logic       scl_f_ff, nxt_scl_f;
	logic       sda_f_ff, nxt_sda_f;
	logic       scl_rise, scl_fall, start_det, stop_det;

	always_comb begin
		nxt_scl_sync = {scl_sync_ff[1:0], scl_i};
		nxt_sda_sync = {sda_sync_ff[1:0], sda_i};
		// a change counts only when stages two and three agree
		nxt_scl_f    = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_f_ff;
		nxt_sda_f    = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_f_ff;
		scl_rise     = nxt_scl_f & ~scl_f_ff;
		scl_fall     = ~nxt_scl_f & scl_f_ff;
		start_det    = scl_f_ff & nxt_scl_f & sda_f_ff & ~nxt_sda_f;
		stop_det     = scl_f_ff & nxt_scl_f & ~sda_f_ff & nxt_sda_f;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
			scl_f_ff    <= 1'b1;
			sda_f_ff    <= 1'b1;
		end else begin
			scl_sync_ff <= nxt_scl_sync;
			sda_sync_ff <= nxt_sda_sync;
			scl_f_ff    <= nxt_scl_f;
			sda_f_ff    <= nxt_sda_f;
		end
	end

	// protocol engine and register file
	wrop_pkg::wrop_state_t state_ff, nxt_state;
	logic [3:0]             bitcnt_ff, nxt_bitcnt;
	logic [7:0]             shift_ff, nxt_shift;
	logic [7:0]             rbuf_ff, nxt_rbuf;
	logic [7:0]             regptr_ff, nxt_regptr;
	logic                   rw_ff, nxt_rw;
	logic                   sda_oe_ff, nxt_sda_oe;
	logic                   sda_ff, nxt_sda;
	wrop_pkg::wrop_olcfg_t  olcfg_ff, nxt_olcfg;
	logic [7:0]             coeff_ff, nxt_coeff;
	logic [15:0]            memptr_ff, nxt_memptr;
	logic                   mem_we;
	logic [7:0]             mem [0:`WROP_RAM_WORDS-1];
	logic [7:0]             rd_byte;

	// read side effects happen when the byte is loaded for shifting out
	always_comb begin
		case (regptr_ff)
			`WROP_OFF_OL_PERIOD_HI: rd_byte = {6'h00, olcfg_ff.period[9:8]};
			`WROP_OFF_OL_PERIOD_LO: rd_byte = olcfg_ff.period[7:0];
			`WROP_OFF_IMP_COEFF:    rd_byte = coeff_ff;
			`WROP_OFF_MEM_PTR_HI:   rd_byte = memptr_ff[15:8];
			`WROP_OFF_MEM_PTR_LO:   rd_byte = memptr_ff[7:0];
			`WROP_OFF_MEM_DATA:     rd_byte = mem[memptr_ff[`WROP_RAM_AW-1:0]];
			default:                rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		nxt_state  = state_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_shift  = shift_ff;
		nxt_rbuf   = rbuf_ff;
		nxt_regptr = regptr_ff;
		nxt_rw     = rw_ff;
		nxt_sda_oe = sda_oe_ff;
		nxt_sda    = 1'b0;
		nxt_olcfg  = olcfg_ff;
		nxt_olcfg.shape_sine = ol_shape_select_i;
		nxt_coeff  = impedance_coeff_i;
		nxt_memptr = memptr_ff;
		mem_we     = 1'b0;
		if (scl_rise) begin
			nxt_shift  = {shift_ff[6:0], sda_f_ff};
			nxt_bitcnt = bitcnt_ff + 4'h1;
		end
		if (start_det) begin
			nxt_state  = wrop_pkg::WROP_ST_ADDR;
			nxt_bitcnt = 4'h0;
			nxt_sda_oe = 1'b0;
		end else if (stop_det) begin
			nxt_state  = wrop_pkg::WROP_ST_IDLE;
			nxt_sda_oe = 1'b0;
		end else if (scl_fall) begin
			case (state_ff)
				wrop_pkg::WROP_ST_ADDR: begin
					if (bitcnt_ff == 4'h8) begin
						if (shift_ff[7:1] == DEV_ADDR) begin
							nxt_rw     = shift_ff[0];
							nxt_sda_oe = 1'b1;
							nxt_state  = wrop_pkg::WROP_ST_ADDR_ACK;
						end else begin
							nxt_state = wrop_pkg::WROP_ST_IDLE;
						end
					end
				end
				wrop_pkg::WROP_ST_ADDR_ACK, wrop_pkg::WROP_ST_RDATA_ACK: begin
					nxt_bitcnt = 4'h0;
					if (state_ff == wrop_pkg::WROP_ST_ADDR_ACK && !rw_ff) begin
						nxt_sda_oe = 1'b0;
						nxt_state  = wrop_pkg::WROP_ST_REG;
					end else if (state_ff == wrop_pkg::WROP_ST_RDATA_ACK && shift_ff[0]) begin
						nxt_sda_oe = 1'b0;
						nxt_state  = wrop_pkg::WROP_ST_IDLE;
					end else begin
						nxt_rbuf   = rd_byte;
						nxt_sda_oe = ~rd_byte[7];
						nxt_state  = wrop_pkg::WROP_ST_RDATA;
						if (regptr_ff == `WROP_OFF_MEM_DATA)
							nxt_memptr = memptr_ff + 16'h0001;
						else
							nxt_regptr = regptr_ff + 8'h01;
					end
				end
				wrop_pkg::WROP_ST_REG: begin
					if (bitcnt_ff == 4'h8) begin
						nxt_regptr = shift_ff;
						nxt_sda_oe = 1'b1;
						nxt_state  = wrop_pkg::WROP_ST_REG_ACK;
					end
				end
				wrop_pkg::WROP_ST_REG_ACK, wrop_pkg::WROP_ST_WDATA_ACK: begin
					nxt_sda_oe = 1'b0;
					nxt_bitcnt = 4'h0;
					nxt_state  = wrop_pkg::WROP_ST_WDATA;
				end
				wrop_pkg::WROP_ST_WDATA: begin
					if (bitcnt_ff == 4'h8) begin
						nxt_sda_oe = 1'b1;
						nxt_state  = wrop_pkg::WROP_ST_WDATA_ACK;
						// the data port holds the register pointer so bursts stream into memory
						if (regptr_ff != `WROP_OFF_MEM_DATA)
							nxt_regptr = regptr_ff + 8'h01;
						case (regptr_ff)
							`WROP_OFF_OL_PERIOD_HI: nxt_olcfg.period[9:8] = shift_ff[1:0];
							`WROP_OFF_OL_PERIOD_LO: nxt_olcfg.period[7:0] = shift_ff;
							`WROP_OFF_MEM_PTR_HI:   nxt_memptr[15:8] = shift_ff;
							`WROP_OFF_MEM_PTR_LO:   nxt_memptr[7:0] = shift_ff;
							`WROP_OFF_MEM_DATA: begin
								mem_we     = 1'b1;
								nxt_memptr = memptr_ff + 16'h0001;
							end
							default: ;
						endcase
					end
				end
				wrop_pkg::WROP_ST_RDATA: begin
					if (bitcnt_ff == 4'h8) begin
						nxt_sda_oe = 1'b0;
						nxt_state  = wrop_pkg::WROP_ST_RDATA_ACK;
					end else begin
						nxt_sda_oe = ~rbuf_ff[3'(4'h7 - bitcnt_ff)];
					end
				end
				default: begin
					nxt_state  = wrop_pkg::WROP_ST_IDLE;
					nxt_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_ff  <= wrop_pkg::WROP_ST_IDLE;
			bitcnt_ff <= 4'h0;
			shift_ff  <= 8'h00;
			rbuf_ff   <= 8'h00;
			regptr_ff <= 8'h00;
			rw_ff     <= 1'b0;
			sda_oe_ff <= 1'b0;
			sda_ff    <= 1'b0;
			olcfg_ff  <= {1'b0, `WROP_RST_OL_PERIOD};
			coeff_ff  <= `WROP_RST_IMP_COEFF;
			memptr_ff <= `WROP_RST_MEM_PTR;
		end else begin
			state_ff  <= nxt_state;
			bitcnt_ff <= nxt_bitcnt;
			shift_ff  <= nxt_shift;
			rbuf_ff   <= nxt_rbuf;
			regptr_ff <= nxt_regptr;
			rw_ff     <= nxt_rw;
			sda_oe_ff <= nxt_sda_oe;
			sda_ff    <= nxt_sda;
			olcfg_ff  <= nxt_olcfg;
			coeff_ff  <= nxt_coeff;
			memptr_ff <= nxt_memptr;
		end
	end

	// no reset on the array; contents are undefined until loaded
	always_ff @(posedge clk_i) begin
		if (mem_we)
			mem[memptr_ff[`WROP_RAM_AW-1:0]] <= shift_ff;
	end

	// open-loop drive: 64 phase steps spread evenly over period * unit cycles
	logic [19:0] acc_ff, nxt_acc;
	logic [5:0]  phase_ff, nxt_phase;
	logic        active_ff, nxt_active;
	logic [7:0]  level_ff, nxt_level;
	logic [19:0] limit;
	logic [19:0] acc_sum;
	logic [3:0]  sidx;
	logic [7:0]  smag;

	always_comb begin
		limit      = 20'(olcfg_ff.period) * 20'(UNIT_CYC);
		acc_sum    = acc_ff + `WROP_OL_PHASE_STEPS;
		nxt_active = ol_enable_i && (olcfg_ff.period != 10'h000);
		nxt_acc    = acc_sum;
		nxt_phase  = phase_ff;
		if (!nxt_active) begin
			nxt_acc   = 20'h00000;
			nxt_phase = 6'h00;
		end else if (acc_sum >= limit) begin
			nxt_acc   = acc_sum - limit;
			nxt_phase = phase_ff + 6'h01;
		end
		sidx = phase_ff[4] ? ~phase_ff[3:0] : phase_ff[3:0];
		case (sidx)
			4'h0: smag = 8'h06;
			4'h1: smag = 8'h13;
			4'h2: smag = 8'h1f;
			4'h3: smag = 8'h2b;
			4'h4: smag = 8'h36;
			4'h5: smag = 8'h41;
			4'h6: smag = 8'h4c;
			4'h7: smag = 8'h55;
			4'h8: smag = 8'h5e;
			4'h9: smag = 8'h66;
			4'ha: smag = 8'h6d;
			4'hb: smag = 8'h73;
			4'hc: smag = 8'h78;
			4'hd: smag = 8'h7b;
			4'he: smag = 8'h7e;
			default: smag = 8'h7f;
		endcase
		if (!active_ff)
			nxt_level = 8'h00;
		else if (olcfg_ff.shape_sine)
			nxt_level = phase_ff[5] ? 8'(-smag) : smag;
		else
			nxt_level = phase_ff[5] ? `WROP_SQUARE_NEG : `WROP_SQUARE_POS;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			acc_ff    <= 20'h00000;
			phase_ff  <= 6'h00;
			active_ff <= 1'b0;
			level_ff  <= 8'h00;
		end else begin
			acc_ff    <= nxt_acc;
			phase_ff  <= nxt_phase;
			active_ff <= nxt_active;
			level_ff  <= nxt_level;
		end
	end

	assign sda_o          = sda_ff;
	assign sda_oe_o       = sda_oe_ff;
	assign drive_active_o = active_ff;
	assign drive_level_o  = level_ff;
endmodule

// *** test/wrop_top_assertions.sv ***
// concurrent checks on the ports of the waveform memory port block
`timescale 1ns/100ps
module wrop_top_checker (
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic       scl_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       ol_enable_i,
	input wire logic       ol_shape_select_i,
	input wire logic       drive_active_o,
	input wire logic [7:0] drive_level_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	en_low_idle_a: assert property (!ol_enable_i |=> !drive_active_o)
		else $error("drive active without enable");
	en_rise_act_a: assert property ($rose(ol_enable_i) |=> drive_active_o)
		else $error("drive did not start one cycle after enable");
	act_cause_a: assert property ($rose(drive_active_o) |-> $past(ol_enable_i))
		else $error("drive started with enable low");
	idle_level_zero_a: assert property (!drive_active_o && !$past(drive_active_o) |-> drive_level_o == 8'h00)
		else $error("drive level not zero while idle");
	square_level_a: assert property (drive_active_o && $past(drive_active_o) && !ol_shape_select_i
		&& !$past(ol_shape_select_i) && !$past(ol_shape_select_i, 2) |-> drive_level_o inside {8'h7f, 8'h81})
		else $error("square drive level off its two values");
	active_level_a: assert property (drive_active_o && $past(drive_active_o) |-> drive_level_o != 8'h00)
		else $error("drive level zero while drive runs");
	sda_low_a: assert property (!sda_o)
		else $error("data pin output value not low");
	ack_change_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data pin drive changed while clock high");
	ack_stands_a: assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*8])
		else $error("data pin drive moved during clock high phase");
endmodule

bind wrop_top wrop_top_checker i_chk (
	.clk_i            (clk_i),
	.nrst_i           (nrst_i),
	.scl_i            (scl_i),
	.sda_o            (sda_o),
	.sda_oe_o         (sda_oe_o),
	.ol_enable_i      (ol_enable_i),
	.ol_shape_select_i(ol_shape_select_i),
	.drive_active_o   (drive_active_o),
	.drive_level_o    (drive_level_o)
);

// *** test/wrop_host.sv ***
// i2c host model that reaches every register of the block over the bus
`timescale 1ns/100ps
module wrop_host #(
	parameter logic [6:0] ADDR = 7'h5a // arbitrary bus address
) (
	input  wire logic       clk_i,
	input  wire logic       sda_oe_i,
	output logic            scl_o = 1'b1,
	output logic            sda_o,
	output logic            got_o = 1'b0,
	output logic [7:0]      rd_o = 8'h00
);
	logic hold = 1'b1;
	// open drain: a released line floats to the pull-up
	assign sda_o = sda_oe_i ? 1'b0 : hold;
	task automatic w(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// waits first so the device lets go of its acknowledge
	task automatic start();
		w(5);
		hold = 1'b1;
		w(5);
		scl_o = 1'b1;
		w(10);
		hold = 1'b0;
		w(10);
		scl_o = 1'b0;
	endtask
	task automatic stop();
		w(5);
		hold = 1'b0;
		w(10);
		scl_o = 1'b1;
		w(10);
		hold = 1'b1;
		w(10);
	endtask
	// eight data bits plus the acknowledge bit; reply is the read byte or the ack level
	task automatic io(input logic [7:0] b, input logic last, input logic rd);
		logic [8:0] t;
		logic [8:0] s;
		t = {b, last};
		for (int i = 8; i >= 0; i--) begin
			w(5);
			hold = t[i];
			w(10);
			scl_o = 1'b1;
			w(10);
			s[i] = sda_o;
			scl_o = 1'b0;
		end
		rd_o = rd ? s[8:1] : {7'h00, s[0]};
		got_o = 1'b1;
		w(1);
		got_o = 1'b0;
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] d[$]);
		start();
		io({ADDR, 1'b0}, 1'b1, 1'b0);
		io(off, 1'b1, 1'b0);
		foreach (d[i]) io(d[i], 1'b1, 1'b0);
		stop();
	endtask
	task automatic rd(input logic [7:0] off, input int n);
		start();
		io({ADDR, 1'b0}, 1'b1, 1'b0);
		io(off, 1'b1, 1'b0);
		start();
		io({ADDR, 1'b1}, 1'b1, 1'b0);
		for (int i = 0; i < n; i++) io(8'hff, i == n - 1, 1'b1);
		stop();
	endtask
endmodule

// *** test/wrop_top_tb.sv ***
// self-checking bench of the waveform memory port block
`timescale 1ns/100ps
module wrop_top_tb;
	logic        clk_i;
	logic        nrst_i;
	logic        ol_en;
	logic        ol_shape;
	logic        scl;
	logic        sda;
	logic        oe;
	logic        act;
	logic        got;
	logic [7:0]  coeff;
	logic [7:0]  lvl;
	logic [7:0]  rdv;
	logic [15:0] rnd = 16'hde22;
	logic [15:0] p;
	logic [7:0]  d[$];
	logic [7:0]  exp_q[$];
	int          err_total = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          cnt;
	wrop_top i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
		.ol_enable_i(ol_en), .ol_shape_select_i(ol_shape), .impedance_coeff_i(coeff),
		.drive_active_o(act), .drive_level_o(lvl));
	wrop_host i_host (.clk_i(clk_i), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda), .got_o(got), .rd_o(rdv));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] off, input logic [7:0] q[$]);
		repeat (q.size() + 2) exp_q.push_back(8'h00);
		i_host.wr(off, q);
	endtask
	task automatic rd(input logic [7:0] off, input logic [7:0] q[$]);
		repeat (3) exp_q.push_back(8'h00);
		exp_q = {exp_q, q};
		i_host.rd(off, q.size());
	endtask
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (got)
			chk("reply", rdv, exp_q.pop_front());
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		nrst_i = 1'b0;
		ol_en = 1'b0;
		ol_shape = 1'b0;
		coeff = 8'h00;
		repeat (8) @(negedge clk_i);
		nrst_i = 1'b1;
		rnd = lfsr(rnd);
		coeff = rnd[7:0];
		repeat (8) @(negedge clk_i);
		rd(8'h2e, {8'h00, 8'hc6, coeff});
		wr(8'h30, {~coeff});
		rd(8'h30, {coeff});
		rd(8'h31, {8'h00});
		rd(8'hfd, {8'h00, 8'h00});
		rnd = lfsr(rnd);
		p = {rnd[15:8], 8'hfe};
		// low byte near its top so the pointer carries into the high byte
		wr(8'hfd, {p[15:8], p[7:0]});
		d = {};
		repeat (4) begin
			rnd = lfsr(rnd);
			d.push_back(rnd[7:0]);
		end
		wr(8'hff, d);
		rd(8'hfd, {8'(p[15:8] + 8'h01), 8'h02});
		wr(8'hfd, {p[15:8], p[7:0]});
		rd(8'hff, d);
		rd(8'hfd, {8'(p[15:8] + 8'h01), 8'h02});
		exp_q.push_back(8'h01);
		i_host.start();
		i_host.io(8'h22, 1'b1, 1'b0);
		i_host.stop();
		wr(8'h2e, {8'h00, 8'h08});
		rd(8'h2e, {8'h00, 8'h08});
		ol_en = 1'b1;
		repeat (2) @(negedge clk_i);
		chk("drive active", {7'h00, act}, 8'h01);
		while (lvl !== 8'h81) @(negedge clk_i);
		cnt = 0;
		while (lvl === 8'h81) begin
			@(negedge clk_i);
			cnt++;
		end
		// half period of 8 units of 24.615 us at 50 ns, a few clocks of slack for the rounded unit
		chk("half period", {7'h00, cnt inside {[8 * 24615 / 100 - 8 : 8 * 24615 / 100 + 8]}}, 8'h01);
		ol_shape = 1'b1;
		repeat (300) @(negedge clk_i);
		// a few phase steps into the positive half: a sine sits below the square's peak
		chk("sine level", {7'h00, lvl inside {[8'h01:8'h7e]}}, 8'h01);
		ol_en = 1'b0;
		repeat (3) @(negedge clk_i);
		chk("idle level", lvl, 8'h00);
		chk("pending", 8'(exp_q.size()), 8'h00);
		close_out();
	end
endmodule
